/* dpm_meas_model.sv */
// power stage sensing model feeding current and bus voltage to the monitor
`default_nettype none
module dpm_meas_model (
  // clock
  input  wire logic        core_clk,
  // set points from the bench
  input  wire logic [15:0] cur_set,
  input  wire logic [15:0] volt_set,
  // sensed values, one cycle of lag like a real sampler
  output var logic  [15:0] out_cur_pm = 16'h0000,
  output var logic  [15:0] bus_volt = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge core_clk) begin
    out_cur_pm <= cur_set;
    bus_volt   <= volt_set;
  end
endmodule : dpm_meas_model
`default_nettype wire

/* dpm_monitor.sv */
// drive protection monitor: overload, bus voltage, current limit, load drop, pre-alarm
//
// Notes on behaviour
// - selection 2: thermal curve, no low-speed derating
// - selection 0 off; 1 derates below 30Hz
// - overload threshold scaled by 20-120% coefficient
// - undervoltage action 0 ignores, 1 faults
// - undervoltage level per voltage class range
// - overvoltage limit level starts stall protection
// - deceleration voltage coefficient 0-100, 0 disables
// - current limit 80-200% of drive rating
// - ordinary mode limits accel+constant; vector accel
// - weak-field selection 1 converts above 50Hz
// - acceleration limit coefficient 0-100, 0 disables
// - constant speed: 0-100 auto, above manual rate
// - load drop after current low beyond time
// - load-drop level 0-100%, zero disables
// - pre-alarm threshold 20-200% of drive rating
// - pre-alarm after continuous excess for delay
// - pre-alarm shows warning code on display
//
// Design decisions made here: strobed register access and the address map.
`include "dpm_params.svh"
`default_nettype none
module dpm_monitor
  import dpm_pkg::*;
#(
  parameter bit          VOLT_380    = 1'b0,
  parameter bit          HEAVY_DUTY  = 1'b1,
  parameter int          TICK_CYCLES = `DPM_TICK_NS / `DPM_CLK_NS,
  parameter logic [31:0] OL_HEAT_LIM = 32'h0000EA60
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // measurements, same clock domain
  input  wire logic [15:0] out_cur_pm,
  input  wire logic [15:0] bus_volt,
  input  wire logic [15:0] out_freq,
  input  wire logic        run_accel,
  input  wire logic        run_const,
  input  wire logic        run_decel,
  // fault, alarm and limiting requests
  output logic             motor_ol_fault,
  output logic             uv_fault,
  output logic             ov_stall_req,
  output logic      [15:0] ov_stall_gain,
  output logic             cur_lim_req,
  output logic      [15:0] cur_lim_gain,
  output logic             cur_lim_auto,
  output logic      [15:0] cur_lim_rate,
  output logic      [15:0] cur_lim_level,
  output logic             load_drop,
  output logic             prealarm,
  output logic      [7:0]  warn_code
);
  // ****************************************
  // variant dependent reset values and ranges
  // ****************************************
  localparam logic [15:0] UV_RST  = VOLT_380 ? `DPM_UV_RST_380 : `DPM_UV_RST_220;
  localparam logic [15:0] UV_MIN  = VOLT_380 ? `DPM_UV_MIN_380 : `DPM_UV_MIN_220;
  localparam logic [15:0] UV_MAX  = VOLT_380 ? `DPM_UV_MAX_380 : `DPM_UV_MAX_220;
  localparam logic [15:0] OV_RST  = VOLT_380 ? `DPM_OV_RST_380 : `DPM_OV_RST_220;
  localparam logic [15:0] OV_MIN  = VOLT_380 ? `DPM_OV_MIN_380 : `DPM_OV_MIN_220;
  localparam logic [15:0] OV_MAX  = VOLT_380 ? `DPM_OV_MAX_380 : `DPM_OV_MAX_220;
  localparam logic [15:0] LIM_RST = HEAVY_DUTY ? `DPM_HEAVY_RST : `DPM_LIGHT_RST;

  if (TICK_CYCLES < 2) begin : g_chk
    $error("dpm_monitor: TICK_CYCLES must be at least 2");
  end

  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] ol_coef;
    logic [15:0] uv_lvl;
    logic [15:0] ov_lvl;
    logic [15:0] dec_vcoef;
    logic [15:0] cur_lim;
    logic [15:0] acc_coef;
    logic [15:0] csp_coef;
    logic [15:0] ld_time;
    logic [15:0] ld_lvl;
    logic [15:0] pa_lvl;
    logic [15:0] pa_time;
    logic [31:0] rdata;
    logic [31:0] heat;
    logic        ol_fault;
    logic        uv_fault;
    logic        ov_stall;
    logic [15:0] ov_gain;
    logic        cl_req;
    logic [15:0] cl_gain;
    logic        cl_auto;
    logic [15:0] cl_rate;
    logic [15:0] cl_level;
    logic        ldrop;
    logic        prealm;
    logic [7:0]  warn;
  } dpm_st_type;

  localparam dpm_st_type ST_RST = '{
    ctrl: `DPM_CTRL_RST, ol_coef: `DPM_OL_COEF_RST, uv_lvl: UV_RST, ov_lvl: OV_RST,
    dec_vcoef: `DPM_VCOEF_RST, cur_lim: LIM_RST, acc_coef: `DPM_VCOEF_RST,
    csp_coef: `DPM_CSP_RST, ld_time: `DPM_LD_TIME_RST, ld_lvl: 16'h0, pa_lvl: LIM_RST,
    pa_time: `DPM_PA_TIME_RST, rdata: 32'h0, heat: 32'h0, ol_fault: 1'b0,
    uv_fault: 1'b0, ov_stall: 1'b0, ov_gain: 16'h0, cl_req: 1'b0, cl_gain: 16'h0,
    cl_auto: 1'b0, cl_rate: 16'h0, cl_level: 16'h0, ldrop: 1'b0, prealm: 1'b0,
    warn: `DPM_WARN_NONE};

  dpm_st_type st_ff;
  dpm_st_type nxt_st;

  // ****************************************
  // helpers
  // ****************************************
  // out-of-range writes saturate instead of being dropped
  function automatic logic [15:0] dpm_clamp(input logic [31:0] v, input logic [15:0] lo,
                                            input logic [15:0] hi);
    if (v < 32'(lo)) begin
      return lo;
    end else if (v > 32'(hi)) begin
      return hi;
    end
    return v[15:0];
  endfunction : dpm_clamp

  function automatic logic [15:0] dpm_pct_pm(input logic [15:0] pct);
    logic [31:0] p;
    p = 32'(pct) * 32'(`DPM_PCT_TO_PM);
    return p[15:0];
  endfunction : dpm_pct_pm

  // ****************************************
  // timing tick and qualification timers
  // ****************************************
  logic        tick;
  logic        ld_cond;
  logic        ld_done;
  logic        pa_cond;
  logic        pa_done;
  logic [15:0] pa_lvl_pm;

  dpm_tick_div #(
    .DIV (TICK_CYCLES)
  ) u_tick (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .tick     (tick)
  );

  assign ld_cond   = (st_ff.ld_lvl != 16'h0) && (out_cur_pm < st_ff.ld_lvl);
  assign pa_lvl_pm = dpm_pct_pm(st_ff.pa_lvl);
  assign pa_cond   = out_cur_pm > pa_lvl_pm;

  dpm_qual_timer u_ldrop (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .tick     (tick),
    .cond     (ld_cond),
    .limit    (st_ff.ld_time),
    .strict   (1'b1),
    .done     (ld_done)
  );

  dpm_qual_timer u_prealm (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .tick     (tick),
    .cond     (pa_cond),
    .limit    (st_ff.pa_time),
    .strict   (1'b0),
    .done     (pa_done)
  );

  // ****************************************
  // next state
  // ****************************************
  dpm_ol_sel_type ol_sel;
  logic [15:0]    ol_thr;
  logic [15:0]    lim_pm;
  logic [31:0]    weak_q;
  logic           cl_phase;
  logic [15:0]    cl_coef;

  always_comb begin
    nxt_st       = st_ff;
    ol_sel       = dpm_ol_sel_type'(st_ff.ctrl[`DPM_CTRL_OLSEL_LSB +: 2]);
    ol_thr       = st_ff.ol_coef;
    lim_pm       = dpm_pct_pm(st_ff.cur_lim);
    weak_q       = 32'h0;
    cl_phase     = 1'b0;
    cl_coef      = 16'h0;
    nxt_st.rdata = 32'h0;

    // register writes
    if (reg_wr) begin
      unique case (reg_addr)
        `DPM_REG_CTRL:      nxt_st.ctrl      = {11'h0, reg_wdata[4:0]};
        `DPM_REG_OL_COEF:   nxt_st.ol_coef   = dpm_clamp(reg_wdata, `DPM_OL_COEF_MIN,
                                                         `DPM_OL_COEF_MAX);
        `DPM_REG_UV_LVL:    nxt_st.uv_lvl    = dpm_clamp(reg_wdata, UV_MIN, UV_MAX);
        `DPM_REG_OV_LVL:    nxt_st.ov_lvl    = dpm_clamp(reg_wdata, OV_MIN, OV_MAX);
        `DPM_REG_DEC_VCOEF: nxt_st.dec_vcoef = dpm_clamp(reg_wdata, `DPM_COEF_MIN,
                                                         `DPM_COEF_MAX);
        `DPM_REG_CUR_LIM:   nxt_st.cur_lim   = dpm_clamp(reg_wdata, `DPM_CLIM_MIN,
                                                         `DPM_CLIM_MAX);
        `DPM_REG_ACC_COEF:  nxt_st.acc_coef  = dpm_clamp(reg_wdata, `DPM_COEF_MIN,
                                                         `DPM_COEF_MAX);
        `DPM_REG_CSP_COEF:  nxt_st.csp_coef  = dpm_clamp(reg_wdata, `DPM_COEF_MIN,
                                                         `DPM_CSP_MAX);
        `DPM_REG_LD_TIME:   nxt_st.ld_time   = dpm_clamp(reg_wdata, `DPM_LD_TIME_MIN,
                                                         `DPM_LD_TIME_MAX);
        `DPM_REG_LD_LVL:    nxt_st.ld_lvl    = dpm_clamp(reg_wdata, `DPM_COEF_MIN,
                                                         `DPM_LD_LVL_MAX);
        `DPM_REG_PA_LVL:    nxt_st.pa_lvl    = dpm_clamp(reg_wdata, `DPM_PA_MIN,
                                                         `DPM_CLIM_MAX);
        `DPM_REG_PA_TIME:   nxt_st.pa_time   = dpm_clamp(reg_wdata, `DPM_COEF_MIN,
                                                         `DPM_PA_TIME_MAX);
        default: ;
      endcase
    end

    // register reads, data valid in the following cycle only
    if (reg_rd) begin
      unique case (reg_addr)
        `DPM_REG_CTRL:      nxt_st.rdata = {16'h0, st_ff.ctrl};
        `DPM_REG_OL_COEF:   nxt_st.rdata = {16'h0, st_ff.ol_coef};
        `DPM_REG_UV_LVL:    nxt_st.rdata = {16'h0, st_ff.uv_lvl};
        `DPM_REG_OV_LVL:    nxt_st.rdata = {16'h0, st_ff.ov_lvl};
        `DPM_REG_DEC_VCOEF: nxt_st.rdata = {16'h0, st_ff.dec_vcoef};
        `DPM_REG_CUR_LIM:   nxt_st.rdata = {16'h0, st_ff.cur_lim};
        `DPM_REG_ACC_COEF:  nxt_st.rdata = {16'h0, st_ff.acc_coef};
        `DPM_REG_CSP_COEF:  nxt_st.rdata = {16'h0, st_ff.csp_coef};
        `DPM_REG_LD_TIME:   nxt_st.rdata = {16'h0, st_ff.ld_time};
        `DPM_REG_LD_LVL:    nxt_st.rdata = {16'h0, st_ff.ld_lvl};
        `DPM_REG_PA_LVL:    nxt_st.rdata = {16'h0, st_ff.pa_lvl};
        `DPM_REG_PA_TIME:   nxt_st.rdata = {16'h0, st_ff.pa_time};
        `DPM_REG_STATUS:    nxt_st.rdata = {23'h0, st_ff.prealm, st_ff.ldrop, st_ff.cl_auto,
                                            st_ff.cl_req, st_ff.ov_stall, st_ff.uv_fault,
                                            st_ff.ol_fault, st_ff.warn != `DPM_WARN_NONE,
                                            1'b0};
        `DPM_REG_EFF_LIM:   nxt_st.rdata = {16'h0, st_ff.cl_level};
        default:            nxt_st.rdata = 32'h0;
      endcase
    end

    // motor thermal overload; selection 1 derates by a quarter at low speed
    if (ol_sel == DPM_OL_STD && out_freq < `DPM_F_LOWSPD) begin
      ol_thr = st_ff.ol_coef - (st_ff.ol_coef >> 2);
    end
    if (ol_sel != DPM_OL_OFF) begin
      if (tick) begin
        if (out_cur_pm > ol_thr) begin
          nxt_st.heat = st_ff.heat + 32'(out_cur_pm - ol_thr);
        end else if (st_ff.heat > `DPM_OL_COOL) begin
          nxt_st.heat = st_ff.heat - `DPM_OL_COOL;
        end else begin
          nxt_st.heat = 32'h0;
        end
      end
      nxt_st.ol_fault = st_ff.ol_fault || (st_ff.heat >= OL_HEAT_LIM);
    end else begin
      nxt_st.heat     = 32'h0;
      nxt_st.ol_fault = 1'b0;
    end

    // bus voltage
    nxt_st.uv_fault = st_ff.ctrl[`DPM_CTRL_UV_ACT] && (bus_volt < st_ff.uv_lvl);
    nxt_st.ov_stall = run_decel && (st_ff.dec_vcoef != 16'h0)
                      && (bus_volt >= st_ff.ov_lvl);
    nxt_st.ov_gain  = st_ff.dec_vcoef;

    // current limit level, converted in the weak-field region
    if (st_ff.ctrl[`DPM_CTRL_WEAK] && out_freq > `DPM_F_WEAK) begin
      weak_q = (32'(lim_pm) * 32'(`DPM_F_WEAK)) / 32'(out_freq);
      lim_pm = weak_q[15:0];
    end
    nxt_st.cl_level = lim_pm;

    // which phase may limit and with which coefficient
    if (run_accel) begin
      cl_phase = st_ff.acc_coef != 16'h0;
      cl_coef  = st_ff.acc_coef;
    end else if (run_const && !st_ff.ctrl[`DPM_CTRL_VECTOR]) begin
      cl_phase = 1'b1;
      cl_coef  = st_ff.csp_coef;
    end
    nxt_st.cl_req  = cl_phase && (out_cur_pm >= lim_pm);
    nxt_st.cl_gain = cl_coef;
    // manual rate in 0.01 Hz/s: 101 gives one step
    nxt_st.cl_auto = run_const && (st_ff.csp_coef <= `DPM_CSP_MANUAL);
    nxt_st.cl_rate = (st_ff.csp_coef > `DPM_CSP_MANUAL) ?
                     (st_ff.csp_coef - `DPM_CSP_MANUAL) : 16'h0;

    // load drop and pre-alarm
    nxt_st.ldrop  = ld_done;
    nxt_st.prealm = pa_done;
    nxt_st.warn   = pa_done ? `DPM_WARN_PREALM : `DPM_WARN_NONE;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign reg_rdata      = st_ff.rdata;
  assign motor_ol_fault = st_ff.ol_fault;
  assign uv_fault       = st_ff.uv_fault;
  assign ov_stall_req   = st_ff.ov_stall;
  assign ov_stall_gain  = st_ff.ov_gain;
  assign cur_lim_req    = st_ff.cl_req;
  assign cur_lim_gain   = st_ff.cl_gain;
  assign cur_lim_auto   = st_ff.cl_auto;
  assign cur_lim_rate   = st_ff.cl_rate;
  assign cur_lim_level  = st_ff.cl_level;
  assign load_drop      = st_ff.ldrop;
  assign prealarm       = st_ff.prealm;
  assign warn_code      = st_ff.warn;

  // ****************************************
  // checks
  // ****************************************
  property p_ol_off;
    @(posedge core_clk) disable iff (sys_rst)
    (st_ff.ctrl[`DPM_CTRL_OLSEL_LSB +: 2] == 2'h0) |=> !motor_ol_fault;
  endproperty
  a_ol_off: assert property (p_ol_off) else $error("overload fault while disabled");

  property p_uv;
    @(posedge core_clk) disable iff (sys_rst)
    (st_ff.ctrl[`DPM_CTRL_UV_ACT] && bus_volt < st_ff.uv_lvl) |=> uv_fault;
  endproperty
  a_uv: assert property (p_uv) else $error("undervoltage not flagged");

  property p_uv_off;
    @(posedge core_clk) disable iff (sys_rst)
    !st_ff.ctrl[`DPM_CTRL_UV_ACT] |=> !uv_fault;
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("undervoltage fault while suppressed");

  property p_ov_off;
    @(posedge core_clk) disable iff (sys_rst)
    (st_ff.dec_vcoef == 16'h0) |=> !ov_stall_req;
  endproperty
  a_ov_off: assert property (p_ov_off) else $error("stall with zero coefficient");

  property p_vec_const;
    @(posedge core_clk) disable iff (sys_rst)
    (st_ff.ctrl[`DPM_CTRL_VECTOR] && run_const && !run_accel) |=> !cur_lim_req;
  endproperty
  a_vec_const: assert property (p_vec_const) else $error("vector mode limited at constant");

  property p_acc_off;
    @(posedge core_clk) disable iff (sys_rst)
    (run_accel && st_ff.acc_coef == 16'h0) |=> !cur_lim_req;
  endproperty
  a_acc_off: assert property (p_acc_off) else $error("accel limit with zero coefficient");

  property p_weak;
    @(posedge core_clk) disable iff (sys_rst)
    (!st_ff.ctrl[`DPM_CTRL_WEAK]) |=> (cur_lim_level == $past(st_ff.cur_lim) * `DPM_PCT_TO_PM);
  endproperty
  a_weak: assert property (p_weak) else $error("limit level converted without weak field");

  property p_ld_recover;
    @(posedge core_clk) disable iff (sys_rst)
    (out_cur_pm >= st_ff.ld_lvl) |=> ##1 !load_drop;
  endproperty
  a_ld_recover: assert property (p_ld_recover) else $error("load drop held after recovery");

  property p_ld_off;
    @(posedge core_clk) disable iff (sys_rst)
    (st_ff.ld_lvl == 16'h0) [*2] |=> !load_drop;
  endproperty
  a_ld_off: assert property (p_ld_off) else $error("load drop while disabled");

  property p_warn;
    @(posedge core_clk) disable iff (sys_rst)
    prealarm |-> (warn_code == `DPM_WARN_PREALM);
  endproperty
  a_warn: assert property (p_warn) else $error("pre-alarm without warning code");

  property p_pa_cause;
    @(posedge core_clk) disable iff (sys_rst)
    $rose(prealarm) |-> $past(out_cur_pm) > $past(st_ff.pa_lvl) * `DPM_PCT_TO_PM;
  endproperty
  a_pa_cause: assert property (p_pa_cause) else $error("pre-alarm without overcurrent");
endmodule : dpm_monitor
`default_nettype wire

/* dpm_monitor_test.sv */
// self-checking bench of the drive protection monitor
`include "dpm_params.svh"
`default_nettype none
module dpm_monitor_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
  logic run_accel = 1'b0, run_const = 1'b0, run_decel = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000, lf = 32'h0000B02D;
  logic [15:0] cur = 16'h0000, volt = 16'h012C, freq = 16'h0BB8, i_pm, v_bus;
  logic [31:0] reg_rdata;
  logic [15:0] ovg, clg, clr, cll;
  logic olf, uvf, ovr, clq, cla, ldr, pal;
  logic [7:0] wcode;
  logic [31:0] q[$];
  int fails = 0, n_checks = 0, cyc = 0;
  // short tick so timers qualify in tens of cycles
  dpm_monitor #(.TICK_CYCLES(4), .OL_HEAT_LIM(32'h00000064)) dut_u (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .out_cur_pm(i_pm),
    .bus_volt(v_bus), .out_freq(freq), .run_accel(run_accel), .run_const(run_const),
    .run_decel(run_decel), .motor_ol_fault(olf), .uv_fault(uvf), .ov_stall_req(ovr),
    .ov_stall_gain(ovg), .cur_lim_req(clq), .cur_lim_gain(clg), .cur_lim_auto(cla),
    .cur_lim_rate(clr), .cur_lim_level(cll), .load_drop(ldr), .prealarm(pal),
    .warn_code(wcode));
  dpm_meas_model model_u (.core_clk(core_clk), .cur_set(cur), .volt_set(volt),
    .out_cur_pm(i_pm), .bus_volt(v_bus));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // the note goes on the queue; the watcher compares in the answer cycle
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    q.push_back(e);
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask : rd
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
  endtask : step
  always @(posedge core_clk) begin
    rd_d <= reg_rd;
    cyc <= cyc + 1;
    if (rd_d) chk(reg_rdata, q.pop_front());
    // far beyond the few hundred cycles the tests need
    if (cyc == 5000) begin
      fails++;
      conclude();
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    step(12);
    sys_rst <= 1'b0;
    rd(`DPM_REG_CTRL, 32'h00000001);
    rd(`DPM_REG_UV_LVL, 32'h000000C8);
    rd(`DPM_REG_OV_LVL, 32'h00000172);
    rd(`DPM_REG_CUR_LIM, 32'h000000A0);
    rd(`DPM_REG_PA_LVL, 32'h000000A0);
    rd(`DPM_REG_LD_TIME, 32'h00000032);
    rd(8'h3C, 32'h00000000);
    wr(`DPM_REG_OL_COEF, 32'h00000010);
    rd(`DPM_REG_OL_COEF, 32'h000000C8);
    $display("registers done");
    wr(`DPM_REG_CTRL, 32'h00000004);
    repeat (4) begin
      lf = lfsr(lf);
      volt <= 16'h00C8 + {9'h000, lf[6:0]};
      step(4);
      chk(uvf, 32'h0);
    end
    volt <= 16'h00C7;
    step(4);
    chk(uvf, 32'h1);
    wr(`DPM_REG_CTRL, 32'h00000000);
    step(4);
    chk(uvf, 32'h0);
    volt <= 16'h0190;
    run_decel <= 1'b1;
    step(4);
    chk({ovr, ovg}, 32'h10032);
    wr(`DPM_REG_DEC_VCOEF, 32'h00000000);
    step(4);
    chk(ovr, 32'h0);
    run_decel <= 1'b0;
    $display("voltage done");
    wr(`DPM_REG_CUR_LIM, 32'h00000064);
    cur <= 16'h0258;
    run_accel <= 1'b1;
    step(4);
    chk({clq, cll}, 32'h003E8);
    wr(`DPM_REG_CTRL, 32'h00000008);
    freq <= 16'h2710;
    step(4);
    chk({clq, cll}, 32'h101F4);
    rd(`DPM_REG_EFF_LIM, 32'h000001F4);
    wr(`DPM_REG_ACC_COEF, 32'h00000000);
    step(4);
    chk(clq, 32'h0);
    run_accel <= 1'b0;
    run_const <= 1'b1;
    step(4);
    chk({clq, cla}, 32'h3);
    chk(clg, 32'h28);
    wr(`DPM_REG_CSP_COEF, 32'h00000065);
    step(4);
    chk({cla, clr}, 32'h00001);
    wr(`DPM_REG_CTRL, 32'h00000018);
    step(4);
    chk(clq, 32'h0);
    run_const <= 1'b0;
    $display("current limit done");
    wr(`DPM_REG_LD_LVL, 32'h000001F4);
    wr(`DPM_REG_LD_TIME, 32'h00000001);
    cur <= 16'h0064;
    step(30);
    chk(ldr, 32'h1);
    cur <= 16'h0258;
    step(4);
    chk(ldr, 32'h0);
    wr(`DPM_REG_LD_LVL, 32'h00000000);
    cur <= 16'h0064;
    step(30);
    chk(ldr, 32'h0);
    wr(`DPM_REG_PA_LVL, 32'h00000014);
    wr(`DPM_REG_PA_TIME, 32'h00000000);
    cur <= 16'h012C;
    step(8);
    chk({pal, wcode}, 32'h109);
    rd(`DPM_REG_STATUS, 32'h00000102);
    cur <= 16'h00B4;
    freq <= 16'h03E8;
    step(4);
    chk({pal, wcode}, 32'h000);
    $display("timers done");
    wr(`DPM_REG_CTRL, 32'h00000002);
    step(40);
    chk(olf, 32'h0);
    wr(`DPM_REG_CTRL, 32'h00000001);
    step(40);
    chk(olf, 32'h1);
    wr(`DPM_REG_CTRL, 32'h00000000);
    step(4);
    chk(olf, 32'h0);
    $display("overload done");
    conclude();
  end
endmodule : dpm_monitor_test
`default_nettype wire

/* dpm_params.svh */
// constants of the drive protection monitor: offsets, resets, ranges, timing
`ifndef DPM_PARAMS_SVH
`define DPM_PARAMS_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define DPM_REG_CTRL      8'h00
`define DPM_REG_OL_COEF   8'h04
`define DPM_REG_UV_LVL    8'h08
`define DPM_REG_OV_LVL    8'h0C
`define DPM_REG_DEC_VCOEF 8'h10
`define DPM_REG_CUR_LIM   8'h14
`define DPM_REG_ACC_COEF  8'h18
`define DPM_REG_CSP_COEF  8'h1C
`define DPM_REG_LD_TIME   8'h20
`define DPM_REG_LD_LVL    8'h24
`define DPM_REG_PA_LVL    8'h28
`define DPM_REG_PA_TIME   8'h2C
`define DPM_REG_STATUS    8'h30
`define DPM_REG_EFF_LIM   8'h34

// ****************************************
// control field positions
// ****************************************
`define DPM_CTRL_OLSEL_LSB 0
`define DPM_CTRL_UV_ACT    2
`define DPM_CTRL_WEAK      3
`define DPM_CTRL_VECTOR    4
`define DPM_CTRL_RST       16'h0001

// ****************************************
// reset values and ranges (overload coefficient and load-drop level in permille, other % in percent, times in 0.1 s)
// ****************************************
`define DPM_OL_COEF_RST  16'h03E8
`define DPM_OL_COEF_MIN  16'h00C8
`define DPM_OL_COEF_MAX  16'h04B0
`define DPM_UV_RST_220   16'h00C8
`define DPM_UV_RST_380   16'h015E
`define DPM_UV_MIN_220   16'h00B4
`define DPM_UV_MAX_220   16'h0118
`define DPM_UV_MIN_380   16'h014A
`define DPM_UV_MAX_380   16'h01E0
`define DPM_OV_RST_220   16'h0172
`define DPM_OV_RST_380   16'h0294
`define DPM_OV_MIN_220   16'h015E
`define DPM_OV_MAX_220   16'h0186
`define DPM_OV_MIN_380   16'h0226
`define DPM_OV_MAX_380   16'h030C
`define DPM_COEF_MAX     16'h0064
`define DPM_COEF_MIN     16'h0000
`define DPM_VCOEF_RST    16'h0032
`define DPM_CLIM_MIN     16'h0050
`define DPM_CLIM_MAX     16'h00C8
`define DPM_HEAVY_RST    16'h00A0
`define DPM_LIGHT_RST    16'h0078
`define DPM_PA_MIN       16'h0014
`define DPM_CSP_RST      16'h0028
`define DPM_CSP_MAX      16'h1388
`define DPM_CSP_MANUAL   16'h0064
`define DPM_LD_TIME_RST  16'h0032
`define DPM_LD_TIME_MIN  16'h0001
`define DPM_LD_TIME_MAX  16'h0258
`define DPM_LD_LVL_MAX   16'h03E8
`define DPM_PA_TIME_RST  16'h0064
`define DPM_PA_TIME_MAX  16'h0BB8
`define DPM_PCT_TO_PM    16'h000A

// ****************************************
// frequencies (0.01 Hz), thermal model, codes, timing
// ****************************************
`define DPM_F_LOWSPD     16'h0BB8
`define DPM_F_WEAK       16'h1388
`define DPM_OL_COOL      32'h0000000A
`define DPM_WARN_PREALM  8'h09
`define DPM_WARN_NONE    8'h00
`define DPM_TICK_NS      100000000
`define DPM_CLK_NS       10

`endif

/* dpm_pkg.sv */
// types shared by the drive protection monitor
`default_nettype none
package dpm_pkg;
  typedef enum logic [1:0] {
    DPM_OL_OFF  = 2'h0,
    DPM_OL_STD  = 2'h1,
    DPM_OL_FLAT = 2'h2,
    DPM_OL_INV  = 2'h3
  } dpm_ol_sel_type;
endpackage : dpm_pkg
`default_nettype wire

/* dpm_qual_timer.sv */
// qualification timer: counts ticks while a condition holds
`default_nettype none
module dpm_qual_timer (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // timing
  input  wire logic        tick,
  input  wire logic        cond,
  input  wire logic [15:0] limit,
  input  wire logic        strict,
  // result
  output logic             done
);
  typedef struct packed {
    logic [15:0] cnt;
  } dpm_qt_st_type;

  dpm_qt_st_type st_ff;
  dpm_qt_st_type nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (!cond) begin
      nxt_st.cnt = 16'h0;
    end else if (tick && st_ff.cnt != 16'hFFFF) begin
      nxt_st.cnt = st_ff.cnt + 16'h1;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // strict: must run past the limit, else reaching it is enough
  assign done = cond && (strict ? (st_ff.cnt > limit) : (st_ff.cnt >= limit));
endmodule : dpm_qual_timer
`default_nettype wire

/* dpm_tick_div.sv */
// divider making the one-cycle 0.1 s timing tick
`default_nettype none
module dpm_tick_div #(
  parameter int DIV = 1000000
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic sys_rst,
  // tick
  output logic      tick
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } dpm_div_st_type;

  dpm_div_st_type st_ff;
  dpm_div_st_type nxt_st;

  if (DIV < 2) begin : g_chk
    $error("dpm_tick_div: DIV must be at least 2");
  end

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.tick = 1'b0;
    if (st_ff.cnt == 32'(DIV - 1)) begin
      nxt_st.cnt  = 32'h0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 32'h1;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick = st_ff.tick;
endmodule : dpm_tick_div
`default_nettype wire
